// *** rxwp_pkg.sv ***
// package for the receive word packer: layouts, field positions, register map
package rxwp_pkg;

  // interface layouts selected by software
  typedef enum logic [1:0] {
    RXWP_L8  = 2'b00,
    RXWP_L10 = 2'b01,
    RXWP_L16 = 2'b11
  } rxwp_layout_t;

  // per-lane receive status from the channel
  typedef struct packed {
    logic [9:0] sym;      // decoded byte in [7:0], raw symbol in [9:0]
    logic       ctrl;
    logic       code_err;
    logic       sync;
    logic       disp_err;
    logic       align;
    logic       rm_del;
    logic       rm_ins;
    logic [1:0] sx_status;
    logic       run_disp;
  } rxwp_lane_t;

  // field positions within one 16-bit half of the wide word
  localparam int RXWP_B_CTRL  = 8;
  localparam int RXWP_B_CERR  = 9;
  localparam int RXWP_B_SYNC  = 10;
  localparam int RXWP_B_DERR  = 11;
  localparam int RXWP_B_ALIGN = 12;
  localparam int RXWP_B_DEL   = 13;
  localparam int RXWP_B_INS   = 14;
  localparam int RXWP_B_RD    = 15;
  localparam int RXWP_HALF    = 16;

  // register map, byte addresses
  localparam logic [3:0] RXWP_A_CTRL   = 4'h0;
  localparam logic [3:0] RXWP_A_STATUS = 4'h4;
  localparam logic [3:0] RXWP_A_WORD   = 4'h8;

  // control register field positions and reset values
  localparam int           RXWP_C_LAYOUT_LSB = 0;
  localparam int           RXWP_C_SX_BIT     = 2;
  localparam rxwp_layout_t RXWP_RST_LAYOUT   = RXWP_L8;
  localparam logic         RXWP_RST_SX       = 1'b0;

  localparam logic [1:0] RXWP_RESP_OKAY   = 2'b00;
  localparam logic [1:0] RXWP_RESP_SLVERR = 2'b10;

endpackage : rxwp_pkg

// *** rxwp_packer.sv ***
// receive word packer with axi4-lite control
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module rxwp_packer (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire rxwp_pkg::rxwp_lane_t lane_lo,
  input  wire rxwp_pkg::rxwp_lane_t lane_hi,
  input  wire logic               lane_valid,
  output logic [31:0]             rx_word,
  output logic                    rx_word_valid,
  input  wire logic [3:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [3:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready
);
  import rxwp_pkg::*;

  rxwp_layout_t layout_r;
  logic         sx_mode_r;
  logic [31:0]  word_nxt;
  logic [15:0]  half_nxt [2];
  logic [31:0]  frames_r;
  logic         aw_hold_r;
  logic         w_hold_r;
  logic [3:0]   awaddr_r;
  logic [31:0]  wdata_r;
  logic [3:0]   wstrb_r;

  // one generate loop builds each 16-bit half from its lane
  genvar g;
  for (g = 0; g < 2; g++) begin : g_half
    rxwp_lane_t ln;
    logic       on;
    assign ln = (g == 0) ? lane_lo : lane_hi;
    // high half only exists in the two-lane layout
    assign on = (g == 0) || (layout_r == RXWP_L16);
    always_comb begin
      half_nxt[g] = 16'h0000;
      if (on) begin
        if (layout_r == RXWP_L10) begin
          half_nxt[g][9:0] = ln.sym;
        end else begin
          half_nxt[g][7:0]         = ln.sym[7:0];
          half_nxt[g][RXWP_B_CTRL] = ln.ctrl;
          half_nxt[g][RXWP_B_CERR] = ln.code_err;
        end
        half_nxt[g][RXWP_B_SYNC]  = ln.sync;
        half_nxt[g][RXWP_B_DERR]  = ln.disp_err;
        half_nxt[g][RXWP_B_ALIGN] = ln.align;
        if (sx_mode_r) begin
          half_nxt[g][RXWP_B_INS:RXWP_B_DEL] = ln.sx_status;
        end else begin
          half_nxt[g][RXWP_B_DEL] = ln.rm_del;
          half_nxt[g][RXWP_B_INS] = ln.rm_ins;
        end
        half_nxt[g][RXWP_B_RD] = ln.run_disp;
      end
    end
  end

  assign word_nxt = {half_nxt[1], half_nxt[0]};

  // whole word registered at once so flags never skew from their data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_word       <= 32'h0000_0000;
      rx_word_valid <= 1'b0;
    end else begin
      rx_word       <= lane_valid ? word_nxt : 32'h0000_0000;
      rx_word_valid <= lane_valid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frames_r <= 32'h0000_0000;
    end else if (lane_valid) begin
      frames_r <= frames_r + 32'h0000_0001;
    end
  end

  // axi4-lite write: address and data taken in either order
  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 4'h0;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end else if (aw_hold_r && w_hold_r) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
    end
  end

  // layout changes take effect on the next receive cycle; mid-stream changes
  // may split a word pair, so software should switch while the link is idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      layout_r  <= RXWP_RST_LAYOUT;
      sx_mode_r <= RXWP_RST_SX;
    end else if (aw_hold_r && w_hold_r && awaddr_r[3:2] == RXWP_A_CTRL[3:2]
                 && wstrb_r[0]) begin
      // the unused layout code 2 falls back to the 8-bit layout
      case (wdata_r[RXWP_C_LAYOUT_LSB +: 2])
        RXWP_L10: layout_r <= RXWP_L10;
        RXWP_L16: layout_r <= RXWP_L16;
        default:  layout_r <= RXWP_L8;
      endcase
      sx_mode_r <= wdata_r[RXWP_C_SX_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RXWP_RESP_OKAY;
    end else if (aw_hold_r && w_hold_r) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_r[3:2] == RXWP_A_CTRL[3:2]) ? RXWP_RESP_OKAY
                                                           : RXWP_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // axi4-lite read: one outstanding, answered the cycle after address
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RXWP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RXWP_RESP_OKAY;
      case (s_axi_araddr[3:2])
        RXWP_A_CTRL[3:2]:   s_axi_rdata <= {29'h0, sx_mode_r, layout_r};
        RXWP_A_STATUS[3:2]: s_axi_rdata <= frames_r;
        RXWP_A_WORD[3:2]:   s_axi_rdata <= rx_word;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RXWP_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : rxwp_packer

`default_nettype wire

// *** rxwp_packer_checker.sv ***
// checker for the receive word packer
`timescale 1ns/1ps
`default_nettype none
module rxwp_packer_checker (
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire rxwp_pkg::rxwp_lane_t lane_lo,
  input wire rxwp_pkg::rxwp_lane_t lane_hi,
  input wire logic                 lane_valid,
  input wire logic [31:0]          rx_word,
  input wire logic                 rx_word_valid
);
  import rxwp_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // upper half nonzero only in the two-lane layout
  property p_vld; $past(aresetn) |-> rx_word_valid == $past(lane_valid); endproperty
  a_vld: assert property (p_vld) else $error("valid not one cycle late");
  property p_zero; $past(aresetn) && !$past(lane_valid) |-> rx_word == 32'h0; endproperty
  a_zero: assert property (p_zero) else $error("idle word not zero");
  property p_stat; rx_word_valid |-> rx_word[12:10] ==
    $past({lane_lo.align, lane_lo.disp_err, lane_lo.sync}); endproperty
  a_stat: assert property (p_stat) else $error("low status bits");
  property p_rd; rx_word_valid |-> rx_word[15] == $past(lane_lo.run_disp); endproperty
  a_rd: assert property (p_rd) else $error("low disparity bit");
  property p_rm; rx_word_valid |-> rx_word[14:13] == $past({lane_lo.rm_ins, lane_lo.rm_del})
    || rx_word[14:13] == $past(lane_lo.sx_status); endproperty
  a_rm: assert property (p_rm) else $error("low rate match bits");
  property p_hi; rx_word[31:16] != 16'h0 |-> {rx_word[31], rx_word[28:16]} == $past({
    lane_hi.run_disp, lane_hi.align, lane_hi.disp_err, lane_hi.sync, lane_hi.code_err,
    lane_hi.ctrl, lane_hi.sym[7:0]}); endproperty
  a_hi: assert property (p_hi) else $error("high half");
  property p_lo16; rx_word[31:16] != 16'h0 |-> rx_word[9:0] ==
    $past({lane_lo.code_err, lane_lo.ctrl, lane_lo.sym[7:0]}); endproperty
  a_lo16: assert property (p_lo16) else $error("low byte in two-lane");
  property p_hirm; rx_word[31:16] != 16'h0 |-> rx_word[30:29] == $past({lane_hi.rm_ins,
    lane_hi.rm_del}) || rx_word[30:29] == $past(lane_hi.sx_status); endproperty
  a_hirm: assert property (p_hirm) else $error("high rate match bits");
endmodule : rxwp_packer_checker
bind rxwp_packer rxwp_packer_checker u_chk (.aclk, .aresetn, .lane_lo, .lane_hi, .lane_valid,
  .rx_word, .rx_word_valid);
`default_nettype wire

// *** rxwp_sink.sv ***
// fabric-side sink model
`timescale 1ns/1ps
`default_nettype none
module rxwp_sink (
  input wire logic        aclk,
  input wire logic [31:0] rx_word,
  input wire logic        rx_word_valid,
  output logic [31:0]     got_r
);
  // latches only valid words; no backpressure exists to apply
  always_ff @(posedge aclk) begin
    if (rx_word_valid) got_r <= rx_word;
  end
endmodule : rxwp_sink
`default_nettype wire

// *** rxwp_packer_tb_top.sv ***
// testbench for the receive word packer
`timescale 1ns/1ps
`default_nettype none
module rxwp_packer_tb_top;
  import rxwp_pkg::*;
  localparam rxwp_lane_t PA = 20'ha96b5;
  localparam rxwp_lane_t PB = 20'h5694a;
  logic aclk = 1'b0, aresetn = 1'b0, lane_valid = 1'b0;
  rxwp_lane_t lane_lo = '0, lane_hi = '0;
  logic [31:0] rx_word, s_axi_wdata = '0, s_axi_rdata, got;
  logic rx_word_valid, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] cd [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h3, 3'h7, 3'h2};
  int error_cnt = 0, total_checks = 0, i;
  always #5 aclk = ~aclk;
  rxwp_packer DUT (.aclk, .aresetn, .lane_lo, .lane_hi, .lane_valid, .rx_word, .rx_word_valid,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  rxwp_sink snk (.aclk, .rx_word, .rx_word_valid, .got_r(got));
  function automatic logic [15:0] hf(rxwp_lane_t l, logic [1:0] m, logic sx);
    return {l.run_disp, sx ? l.sx_status : {l.rm_ins, l.rm_del}, l.align, l.disp_err, l.sync,
      m == RXWP_L10 ? l.sym : {l.code_err, l.ctrl, l.sym[7:0]}};
  endfunction : hf
  function automatic logic [31:0] ew(logic [1:0] m, logic sx, rxwp_lane_t a, rxwp_lane_t b);
    return m == RXWP_L16 ? {hf(b, m, sx), hf(a, m, sx)} : {16'h0, hf(a, m, sx)};
  endfunction : ew
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, s, e);
    end
  endtask : chk
  task end_sim(input bit to);
    if (to) error_cnt++;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk) s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge aclk) if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 20) end_sim(1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask : wr
  task rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge aclk) s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge aclk) if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 20) end_sim(1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask : rd
  // two back-to-back words with the lanes swapped catch any lane mix-up
  task run(input logic [1:0] m, input logic sx);
    @(posedge aclk) lane_valid <= 1'b1;
    lane_lo <= PA;
    lane_hi <= PB;
    @(posedge aclk) lane_lo <= PB;
    lane_hi <= PA;
    #1 chk(rx_word, ew(m, sx, PA, PB));
    @(posedge aclk) lane_valid <= 1'b0;
    #1 chk(rx_word, ew(m, sx, PB, PA));
    @(posedge aclk) #1 chk(rx_word, 32'h0);
    chk(got, ew(m, sx, PB, PA));
  endtask : run
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(RXWP_A_CTRL, 32'h0, RXWP_RESP_OKAY);
    for (i = 0; i < 7; i++) begin
      wr(RXWP_A_CTRL, {29'h0, cd[i]}, RXWP_RESP_OKAY);
      run(cd[i][1:0], cd[i][2]);
    end
    rd(RXWP_A_STATUS, 32'he, RXWP_RESP_OKAY);
    wr(RXWP_A_WORD, 32'hffff_ffff, RXWP_RESP_SLVERR);
    wr(4'hc, 32'h0000_0001, RXWP_RESP_SLVERR);
    rd(RXWP_A_CTRL, 32'h0, RXWP_RESP_OKAY);
    rd(4'hc, 32'h0, RXWP_RESP_SLVERR);
    rd(RXWP_A_WORD, 32'h0, RXWP_RESP_OKAY);
    end_sim(0);
  end
endmodule : rxwp_packer_tb_top
`default_nettype wire
